//--- design/rpc_pkg.sv
// Constants and register map of the raw packet channel
package rpc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [5:0] REG_CTRL   = 6'h00;
    localparam logic [5:0] REG_IFIELD = 6'h04;
    localparam logic [5:0] REG_SHORT  = 6'h08;
    localparam logic [5:0] REG_PLEN   = 6'h0c;
    localparam logic [5:0] REG_STATUS = 6'h10;
    localparam logic [5:0] REG_ROFF   = 6'h14;
    localparam logic [5:0] REG_RIFLD  = 6'h18;
    localparam logic [5:0] REG_CTXID  = 6'h1c;
    localparam logic [5:0] REG_DROPS  = 6'h20;

    // ------------------------------------------------------------
    // Control bit positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_LONG  = 1;
    localparam int CTRL_MULTI = 2;
    localparam int CTRL_SHORT = 3;
    localparam int CTRL_END   = 4;
    localparam int CTRL_DISC  = 5;
    localparam logic [31:0] IFIELD_RST = 32'h0000_0000;
    localparam logic [7:0]  CTXID_RST  = 8'h00;

    // ------------------------------------------------------------
    // Protocol and datapath figures
    // ------------------------------------------------------------
    localparam logic [7:0]  CTXID_ENCAP = 8'h04;
    localparam logic [7:0]  CTXID_IPI3  = 8'h07;
    localparam logic [8:0]  BURST_WORDS = 9'h100;
    localparam logic [31:0] WORD_BYTES  = 32'h0000_0008;

    // Transmit connection states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_REQ  = 2'b01,
        TX_PKT  = 2'b10,
        TX_OPEN = 2'b11
    } rpc_tx_st_t;

endpackage : rpc_pkg

//--- design/rpc_q_if.sv
// Interface between the channel and its receive queue
`timescale 1ns/100ps
interface rpc_q_if #(parameter int W = 65);
    logic          wr_valid;
    logic [W-1:0]  wr_data;
    logic          full;
    logic          rd_valid;
    logic [W-1:0]  rd_data;
    logic          rd_ready;
    logic [15:0]   level;
    modport src (output wr_valid, wr_data, rd_ready,
                 input  full, rd_valid, rd_data, level);
    modport que (input  wr_valid, wr_data, rd_ready,
                 output full, rd_valid, rd_data, level);
endinterface : rpc_q_if

//--- design/rpc_sync.sv
// Two-stage synchroniser for link pins
`timescale 1ns/100ps
module rpc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // Pins in, synchronised out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rpc_sync_state_t;

    rpc_sync_state_t q, d;

    // First stage feeds only the second
    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) q <= '0;
        else         q <= d;
    end

    assign dout = q.s2;
endmodule : rpc_sync

//--- design/rpc_rx_queue.sv
// Arrival-order receive queue in onboard memory
`timescale 1ns/100ps
module rpc_rx_queue #(
    parameter int W     = 65,
    parameter int DEPTH = 512
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Queue port
    rpc_q_if.que      qp
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 32768)
        $error("rpc_rx_queue: DEPTH must be a power of two");

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } rpc_q_state_t;

    rpc_q_state_t q, d;
    logic [W-1:0] mem [DEPTH];
    logic         push, pop;

    assign qp.full     = (q.cnt == (AW+1)'(DEPTH));
    assign qp.rd_valid = (q.cnt != '0);
    assign qp.rd_data  = mem[q.rp];
    assign qp.level    = 16'(q.cnt);
    assign push = qp.wr_valid && !qp.full;
    assign pop  = qp.rd_valid && qp.rd_ready;

    // Strict first in, first out: the head blocks all behind it
    always_comb begin
        d = q;
        if (push) d.wp = q.wp + 1'b1;
        if (pop)  d.rp = q.rp + 1'b1;
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) q <= '0;
        else         q <= d;
    end

    // Storage needs no reset
    always_ff @(posedge mclk) begin
        if (push) mem[q.wp] <= qp.wr_data;
    end

    AST_HEAD_HOLDS: assert property (@(posedge mclk) disable iff (sys_rst)
        qp.rd_valid && !qp.rd_ready |=> $stable(qp.rd_data))
        else $error("queue head changed while not taken");
endmodule : rpc_rx_queue

//--- design/rpc_channel.sv
// Raw physical-layer packet channel, transmit and receive
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module rpc_channel #(
    parameter int QDEPTH = 512
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [5:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Host transmit words
    input  wire logic [63:0] tx_word_data,
    input  wire logic        tx_word_valid,
    input  wire logic        tx_word_last,
    output logic             tx_word_ready,
    // Host receive words
    output logic      [63:0] rx_word_data,
    output logic             rx_word_last,
    output logic             rx_word_valid,
    input  wire logic        rx_word_ready,
    // Link transmit side
    output logic             link_tx_request,
    output logic      [31:0] link_tx_ifield,
    output logic             link_tx_packet,
    output logic             link_tx_burst,
    output logic             link_tx_valid,
    output logic      [63:0] link_tx_data,
    input  wire logic        link_tx_connect,
    input  wire logic        link_tx_ready,
    // Link receive side
    input  wire logic        link_rx_request,
    input  wire logic [31:0] link_rx_ifield,
    input  wire logic        link_rx_packet,
    input  wire logic        link_rx_valid,
    input  wire logic [63:0] link_rx_data,
    output logic             link_rx_connect
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rpc_pkg::rpc_tx_st_t st;
        logic        req;
        logic        pkt;
        logic        burst;
        logic        txv;
        logic [63:0] txd;
        logic [8:0]  bcnt;
        logic        first;
        logic [31:0] sent;
        logic        rx_en;
        logic        long_c;
        logic        multi;
        logic        sh_en;
        logic        end_req;
        logic        disc_req;
        logic [31:0] ifield;
        logic [7:0]  sh_words;
        logic [31:0] plen;
        logic [7:0]  ctxid;
        logic        id_err;
        logic        conn;
        logic [31:0] rifield;
        logic [63:0] hold;
        logic        holdv;
        logic        dropping;
        logic [15:0] drops;
        logic [31:0] roff;
        logic [31:0] rdata;
    } rpc_top_state_t;

    rpc_top_state_t q, d;
    rpc_q_if #(.W(65)) qif ();

    logic        rx_req_s, rx_pk_s, rx_v_s, conn_s, rdy_s;
    logic [31:0] rx_if_s;
    logic [63:0] rx_d_s;
    logic        take, endp, gap, push_v;
    logic [64:0] push_d;
    logic [8:0]  limit;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    // Every link pin, data included, crosses two flops together
    rpc_sync #(.W(101)) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .din     ({link_rx_request, link_rx_ifield, link_rx_packet,
                   link_rx_valid, link_rx_data, link_tx_connect,
                   link_tx_ready}),
        .dout    ({rx_req_s, rx_if_s, rx_pk_s, rx_v_s, rx_d_s,
                   conn_s, rdy_s})
    );

    rpc_rx_queue #(.W(65), .DEPTH(QDEPTH)) u_queue (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .qp      (qif.que)
    );

    // ------------------------------------------------------------
    // Combinational datapath and control
    // ------------------------------------------------------------
    // First burst may be short; zero words means full length
    assign limit = (q.first && q.sh_en && q.sh_words != 8'h00) ?
                   {1'b0, q.sh_words} : rpc_pkg::BURST_WORDS;
    // One idle cycle between bursts marks the boundary
    assign gap   = !q.burst;
    assign tx_word_ready = (q.st == rpc_pkg::TX_PKT) && rdy_s && !gap;
    assign take  = tx_word_ready && tx_word_valid;

    always_comb begin
        d      = q;
        endp   = 1'b0;
        push_v = 1'b0;
        push_d = '0;
        d.txv  = 1'b0;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                rpc_pkg::REG_CTRL: begin
                    d.rx_en  = reg_wdata[rpc_pkg::CTRL_RX_EN];
                    d.long_c = reg_wdata[rpc_pkg::CTRL_LONG];
                    d.multi  = reg_wdata[rpc_pkg::CTRL_MULTI];
                    d.sh_en  = reg_wdata[rpc_pkg::CTRL_SHORT];
                end
                rpc_pkg::REG_IFIELD: d.ifield = reg_wdata;
                rpc_pkg::REG_SHORT:  d.sh_words = reg_wdata[10:3];
                rpc_pkg::REG_PLEN:   d.plen = reg_wdata;
                rpc_pkg::REG_CTXID: begin
                    // Reserved identifiers are refused and flagged
                    if (reg_wdata[7:0] == rpc_pkg::CTXID_ENCAP ||
                        reg_wdata[7:0] == rpc_pkg::CTXID_IPI3) begin
                        d.id_err = 1'b1;
                    end else begin
                        d.ctxid  = reg_wdata[7:0];
                        d.id_err = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Transmit connection and packet sequencing
        unique case (q.st)
            rpc_pkg::TX_IDLE: begin
                d.disc_req = 1'b0;
                d.end_req  = 1'b0;
                // Start only from idle, once the last link has dropped
                if (tx_word_valid && !conn_s) begin
                    d.st  = rpc_pkg::TX_REQ;
                    d.req = 1'b1;
                end
            end
            rpc_pkg::TX_REQ: begin
                if (conn_s) begin
                    d.st    = rpc_pkg::TX_PKT;
                    d.pkt   = 1'b1;
                    d.burst = 1'b1;
                    d.bcnt  = '0;
                    d.first = 1'b1;
                    d.sent  = '0;
                end
            end
            rpc_pkg::TX_PKT: begin
                if (gap) d.burst = 1'b1;
                if (take) begin
                    d.txd  = tx_word_data;
                    d.txv  = 1'b1;
                    d.sent = q.sent + rpc_pkg::WORD_BYTES;
                    d.bcnt = q.bcnt + 9'h001;
                    if (q.bcnt + 9'h001 == limit) begin
                        d.burst = 1'b0;
                        d.bcnt  = '0;
                        d.first = 1'b0;
                    end
                end
                // In multi-write mode the packet stays up across writes until the end command or, if plen is set, plen bytes
                endp = q.end_req
                    || (take && tx_word_last && !q.multi)
                    || (take && q.multi && q.plen != '0
                        && q.sent + rpc_pkg::WORD_BYTES >= q.plen);
                if (endp) begin
                    d.pkt     = 1'b0;
                    d.burst   = 1'b0;
                    d.end_req = 1'b0;
                    d.req     = q.long_c;
                    d.st      = q.long_c ? rpc_pkg::TX_OPEN
                                         : rpc_pkg::TX_IDLE;
                end
            end
            rpc_pkg::TX_OPEN: begin
                d.end_req = 1'b0;
                // Long-term link drops only on host command
                if (q.disc_req) begin
                    d.st       = rpc_pkg::TX_IDLE;
                    d.req      = 1'b0;
                    d.disc_req = 1'b0;
                end else if (tx_word_valid) begin
                    d.st    = rpc_pkg::TX_PKT;
                    d.pkt   = 1'b1;
                    d.burst = 1'b1;
                    d.bcnt  = '0;
                    d.first = 1'b1;
                    d.sent  = '0;
                end
            end
        endcase

        // Command pulses: a new write wins over consumption
        if (reg_wr && reg_addr == rpc_pkg::REG_CTRL) begin
            if (reg_wdata[rpc_pkg::CTRL_END])  d.end_req  = 1'b1;
            if (reg_wdata[rpc_pkg::CTRL_DISC]) d.disc_req = 1'b1;
        end

        // Receive: while enabled, accept every connection without asking anyone
        d.conn = q.rx_en && rx_req_s;
        if (d.conn && !q.conn) d.rifield = rx_if_s;

        // Hold one word so the last of a packet can be marked
        if (q.conn && rx_pk_s && rx_v_s) begin
            d.hold  = rx_d_s;
            d.holdv = 1'b1;
            if (q.holdv) begin
                push_v = 1'b1;
                push_d = {1'b0, q.hold};
            end
        end else if (!rx_pk_s && q.holdv) begin
            d.holdv = 1'b0;
            push_v  = 1'b1;
            push_d  = {1'b1, q.hold};
        end

        // Out of room: discard the rest of the packet
        if (push_v && (qif.full || q.dropping)) begin
            if (!q.dropping) d.drops = q.drops + 16'h0001;
            d.dropping = 1'b1;
            push_v     = 1'b0;
        end
        if (!rx_pk_s && !q.holdv) d.dropping = 1'b0;

        // Offset within the packet the host is reading
        if (qif.rd_valid && rx_word_ready) begin
            d.roff = qif.rd_data[64] ? 32'h0000_0000
                                     : q.roff + rpc_pkg::WORD_BYTES;
        end

        // Register reads, answered in the following cycle only
        d.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                rpc_pkg::REG_CTRL:
                    d.rdata = {28'h0, q.sh_en, q.multi, q.long_c, q.rx_en};
                rpc_pkg::REG_IFIELD: d.rdata = q.ifield;
                rpc_pkg::REG_SHORT:  d.rdata = {21'h0, q.sh_words, 3'h0};
                rpc_pkg::REG_PLEN:   d.rdata = q.plen;
                rpc_pkg::REG_STATUS:
                    d.rdata = {qif.level, 9'h0, q.id_err, q.dropping,
                               q.conn, q.pkt, q.req, q.st};
                rpc_pkg::REG_ROFF:   d.rdata = q.roff;
                rpc_pkg::REG_RIFLD:  d.rdata = q.rifield;
                rpc_pkg::REG_CTXID:  d.rdata = {24'h0, q.ctxid};
                rpc_pkg::REG_DROPS:  d.rdata = {16'h0, q.drops};
                default:             d.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q        <= '0;
            q.st     <= rpc_pkg::TX_IDLE;
            q.ifield <= rpc_pkg::IFIELD_RST;
            q.ctxid  <= rpc_pkg::CTXID_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign qif.wr_valid    = push_v;
    assign qif.wr_data     = push_d;
    assign qif.rd_ready    = rx_word_ready;
    assign rx_word_valid   = qif.rd_valid;
    assign rx_word_data    = qif.rd_data[63:0];
    assign rx_word_last    = qif.rd_data[64];
    assign reg_rdata       = q.rdata;
    assign link_tx_request = q.req;
    assign link_tx_ifield  = q.ifield;
    assign link_tx_packet  = q.pkt;
    assign link_tx_burst   = q.burst;
    assign link_tx_valid   = q.txv;
    assign link_tx_data    = q.txd;
    assign link_rx_connect = q.conn;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_RX_ACCEPT: assert property (
        q.rx_en && rx_req_s |=> link_rx_connect)
        else $error("enabled receiver did not accept connection");

    AST_CTXID_FREE: assert property (
        q.ctxid != rpc_pkg::CTXID_ENCAP && q.ctxid != rpc_pkg::CTXID_IPI3)
        else $error("reserved context identifier in use");

    AST_DROP_COUNT: assert property (
        $rose(q.dropping) |-> q.drops == $past(q.drops) + 16'h0001)
        else $error("dropped packet not counted");

    AST_ONE_CONN: assert property (
        $rose(link_tx_request) |-> $past(q.st) == rpc_pkg::TX_IDLE)
        else $error("second connection requested");

    AST_RX_QUEUED: assert property (
        q.conn && rx_pk_s && rx_v_s && q.holdv && !qif.full
        && !q.dropping |-> qif.wr_valid && !qif.wr_data[64])
        else $error("received word not queued");

    AST_OFFSET: assert property (
        rx_word_valid && rx_word_ready && !rx_word_last
        |=> q.roff == $past(q.roff) + rpc_pkg::WORD_BYTES)
        else $error("receive offset did not advance");

    AST_SINGLE_DISC: assert property (
        $fell(link_tx_packet) && !q.long_c |-> !link_tx_request)
        else $error("single-packet connection left open");

    AST_LONG_HOLD: assert property (
        q.st == rpc_pkg::TX_OPEN && !q.disc_req |=> link_tx_request)
        else $error("long-term connection dropped unasked");

    AST_SINGLE_END: assert property (
        take && tx_word_last && !q.multi |=> !link_tx_packet ##1
        !link_tx_valid)
        else $error("single-write packet did not end");

    AST_DATA_ONLY: assert property (
        link_tx_valid |-> link_tx_data == $past(tx_word_data)
        && $past(take))
        else $error("transmitted word not host data");

    AST_IFIELD_PASS: assert property (
        $rose(link_rx_connect) |=> q.rifield == $past(rx_if_s, 2))
        else $error("received I-field altered");

endmodule : rpc_channel

//--- tb/rpc_peer_model.sv
// Remote link node model facing the raw packet channel
`timescale 1ns/100ps
module rpc_peer_model (
    // Clock
    input  wire logic        mclk,
    // Transmit side seen from the far end
    input  wire logic        link_tx_request,
    input  wire logic [31:0] link_tx_ifield,
    input  wire logic        link_tx_valid,
    input  wire logic [63:0] link_tx_data,
    output logic             link_tx_connect,
    output logic             link_tx_ready,
    // Receive side driven by the far end
    output logic             link_rx_request,
    output logic [31:0]      link_rx_ifield,
    output logic             link_rx_packet,
    output logic             link_rx_valid,
    output logic [63:0]      link_rx_data,
    input  wire logic        link_rx_connect
);
    logic [63:0] got_q[$];
    logic [31:0] got_ifield;
    int          req_count = 0;

    initial begin
        {link_tx_connect, link_tx_ready, link_rx_request} = 3'b000;
        {link_rx_packet, link_rx_valid} = 2'b00;
        link_rx_ifield = 32'h0000_0000;
        link_rx_data   = 64'h0000_0000_0000_0000;
    end

    // Accept each request one edge later; words are 8 bytes
    always @(posedge mclk) begin
        if (link_tx_request && !link_tx_connect) begin
            got_ifield <= link_tx_ifield;
            req_count++;
        end
        link_tx_connect <= link_tx_request;
        link_tx_ready   <= link_tx_request;
        if (link_tx_valid) got_q.push_back(link_tx_data);
    end

    // One packet per connection, whole words only
    task automatic send_rx(input logic [31:0] ifl, input int n,
                           input logic [63:0] base, output bit ok);
        int k;
        ok = 1'b0;
        @(posedge mclk);
        link_rx_ifield  <= ifl;
        link_rx_request <= 1'b1;
        for (k = 0; k < 50 && !ok; k++) begin
            @(posedge mclk);
            ok = link_rx_connect;
        end
        for (k = 0; k < n; k++) begin
            link_rx_packet <= 1'b1;
            link_rx_valid  <= 1'b1;
            link_rx_data   <= base + 64'(k);
            @(posedge mclk);
        end
        // Released data flips, never a stale copy
        link_rx_valid  <= 1'b0;
        link_rx_packet <= 1'b0;
        link_rx_data   <= ~link_rx_data;
        repeat (4) @(posedge mclk);
        link_rx_request <= 1'b0;
        for (k = 0; k < 50 && link_rx_connect; k++) @(posedge mclk);
    endtask : send_rx
endmodule : rpc_peer_model

//--- tb/tb_top.sv
// Self-checking bench for the raw packet channel
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic        mclk, sys_rst, reg_wr, reg_rd, tx_word_valid, tx_word_last;
    logic [5:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, link_tx_ifield, link_rx_ifield, d;
    logic [63:0] tx_word_data, rx_word_data, link_tx_data, link_rx_data;
    logic        tx_word_ready, rx_word_last, rx_word_valid, rx_word_ready;
    logic        link_tx_request, link_tx_packet, link_tx_burst, link_tx_valid;
    logic        link_tx_connect, link_tx_ready, link_rx_request, ok;
    logic        link_rx_packet, link_rx_valid, link_rx_connect;
    int          err_total = 0, check_count = 0;

    rpc_channel #(.QDEPTH(8)) uut (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_word_data(tx_word_data),
        .tx_word_valid(tx_word_valid), .tx_word_last(tx_word_last),
        .tx_word_ready(tx_word_ready), .rx_word_data(rx_word_data),
        .rx_word_last(rx_word_last), .rx_word_valid(rx_word_valid),
        .rx_word_ready(rx_word_ready), .link_tx_request(link_tx_request),
        .link_tx_ifield(link_tx_ifield), .link_tx_packet(link_tx_packet),
        .link_tx_burst(link_tx_burst), .link_tx_valid(link_tx_valid),
        .link_tx_data(link_tx_data), .link_tx_connect(link_tx_connect),
        .link_tx_ready(link_tx_ready), .link_rx_request(link_rx_request),
        .link_rx_ifield(link_rx_ifield), .link_rx_packet(link_rx_packet),
        .link_rx_valid(link_rx_valid), .link_rx_data(link_rx_data),
        .link_rx_connect(link_rx_connect));
    rpc_peer_model peer (.mclk(mclk), .link_tx_request(link_tx_request),
        .link_tx_ifield(link_tx_ifield), .link_tx_valid(link_tx_valid),
        .link_tx_data(link_tx_data), .link_tx_connect(link_tx_connect),
        .link_tx_ready(link_tx_ready), .link_rx_request(link_rx_request),
        .link_rx_ifield(link_rx_ifield), .link_rx_packet(link_rx_packet),
        .link_rx_valid(link_rx_valid), .link_rx_data(link_rx_data),
        .link_rx_connect(link_rx_connect));

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Register bus strobes, one cycle each
    task automatic reg_write(input logic [5:0] a, input logic [31:0] v);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [5:0] a);
        @(posedge mclk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    // Bounded wait for a level; a timeout ends the run
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int k;
        #1;
        for (k = 0; k < lim && s !== v; k++) begin
            @(posedge mclk);
            #1;
        end
        `CHK("level wait", v, s)
        if (s !== v) tally_and_finish();
    endtask : wait_lvl
    // One host write of n words
    task automatic send_tx(input int n, input logic [63:0] base);
        @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            {tx_word_valid, tx_word_last} <= {1'b1, i == n - 1};
            tx_word_data <= base + 64'(i);
            wait_lvl(tx_word_ready, 1'b1, 300);
            @(posedge mclk);
        end
        tx_word_valid <= 1'b0;
    endtask : send_tx
    task automatic take_rx(input logic [63:0] e, input logic last);
        wait_lvl(rx_word_valid, 1'b1, 50);
        `CHK("rx word", e, rx_word_data)
        `CHK("rx last", last, rx_word_last)
        @(posedge mclk);
        rx_word_ready <= 1'b1;
        @(posedge mclk);
        rx_word_ready <= 1'b0;
    endtask : take_rx

    task automatic t_ctxid();
        reg_read(rpc_pkg::REG_CTXID);
        `CHK("ctxid rst", {24'h0, rpc_pkg::CTXID_RST}, d)
        reg_write(rpc_pkg::REG_CTXID, 32'h0000_00ff);
        reg_write(rpc_pkg::REG_CTXID, 32'h0000_0007);
        reg_read(rpc_pkg::REG_CTXID);
        `CHK("ctxid", 32'h0000_00ff, d)
        reg_read(rpc_pkg::REG_STATUS);
        `CHK("id_err", 1'b1, d[6])
    endtask : t_ctxid

    task automatic t_tx_single();
        reg_write(rpc_pkg::REG_IFIELD, 32'h5a5a_0003);
        send_tx(3, 64'h1111_0000_0000_0000);
        wait_lvl(link_tx_request, 1'b0, 50);
        `CHK("pkt end", 1'b0, link_tx_packet)
        send_tx(1, 64'h1111_0000_0000_0003);
        wait_lvl(link_tx_request, 1'b0, 50);
        repeat (3) @(posedge mclk);
        `CHK("requests", 2, peer.req_count)
        `CHK("ifield", 32'h5a5a_0003, peer.got_ifield)
        `CHK("count", 4, peer.got_q.size())
        for (int i = 0; i < 4; i++)
            `CHK("tx", 64'h1111_0000_0000_0000 + i, peer.got_q[i])
    endtask : t_tx_single

    task automatic t_tx_long();
        reg_write(rpc_pkg::REG_SHORT, 32'h0000_0010);
        reg_write(rpc_pkg::REG_CTRL, 32'h0000_000e);
        send_tx(2, 64'h0);
        #1;
        `CHK("short burst", 1'b0, link_tx_burst)
        repeat (8) @(posedge mclk);
        `CHK("pkt held", 1'b1, link_tx_packet)
        send_tx(1, 64'h2);
        reg_write(rpc_pkg::REG_CTRL, 32'h0000_0016);
        wait_lvl(link_tx_packet, 1'b0, 20);
        `CHK("still open", 1'b1, link_tx_request)
        reg_write(rpc_pkg::REG_PLEN, 32'h0000_0010);
        send_tx(2, 64'h3);
        wait_lvl(link_tx_packet, 1'b0, 20);
        reg_write(rpc_pkg::REG_CTRL, 32'h0000_0022);
        wait_lvl(link_tx_request, 1'b0, 20);
    endtask : t_tx_long

    task automatic t_rx();
        reg_write(rpc_pkg::REG_CTRL, 32'h0000_0001);
        peer.send_rx(32'hc0de_0009, 2, 64'h2222_0000_0000_0000, ok);
        `CHK("accept", 1'b1, ok)
        peer.send_rx(32'h0000_00f1, 1, 64'h3333_0000_0000_0000, ok);
        `CHK("accept", 1'b1, ok)
        reg_read(rpc_pkg::REG_RIFLD);
        `CHK("rx ifield", 32'h0000_00f1, d)
        take_rx(64'h2222_0000_0000_0000, 1'b0);
        reg_read(rpc_pkg::REG_ROFF);
        `CHK("offset", 32'h0000_0008, d)
        take_rx(64'h2222_0000_0000_0001, 1'b1);
        reg_read(rpc_pkg::REG_ROFF);
        `CHK("offset", 32'h0000_0000, d)
        take_rx(64'h3333_0000_0000_0000, 1'b1);
        peer.send_rx(32'h0000_0001, 10, 64'h0, ok);
        reg_read(rpc_pkg::REG_DROPS);
        `CHK("drops", 32'h0000_0001, d)
    endtask : t_rx

    // Reset for two cycles, then scenarios in turn
    initial begin
        {mclk, sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b01, 40'h0};
        {tx_word_valid, tx_word_last, tx_word_data, rx_word_ready} = 'h0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_ctxid();
        t_tx_single();
        t_tx_long();
        t_rx();
        tally_and_finish();
    end
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
